// ===== common/opdec_pkg.sv
// opdec_pkg: shared constants, enumerations and carriers for the
// opcode decoder and execution-state counter.
// assumes: instruction bytes arrive first byte first, one whole instruction at a time.
package opdec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // instruction window
  localparam int FETCH_BYTES = 8;           // bytes presented per instruction

  // first-byte codes
  localparam logic [7:0] OPC_BIT_REG_TEST  = 8'h7C; // register-indirect, test only
  localparam logic [7:0] OPC_BIT_REG_MOD   = 8'h7D; // register-indirect, set/invert/clear
  localparam logic [7:0] OPC_BIT_ABS8_TEST = 8'h7E; // 8-bit absolute, test only
  localparam logic [7:0] OPC_BIT_ABS8_MOD  = 8'h7F; // 8-bit absolute, set/invert/clear
  localparam logic [7:0] OPC_EXT_6A        = 8'h6A; // prefix of long absolute forms
  localparam logic [7:0] OPC_EXT_01        = 8'h01; // prefix of extended forms
  localparam logic [7:0] OPC_CALL_REG      = 8'h5D; // call through register
  localparam logic [7:0] OPC_CALL_ABS24    = 8'h5E; // call to 24-bit absolute
  localparam logic [7:0] OPC_CALL_MEMIND   = 8'h5F; // call through 8-bit table address

  // second-byte codes after the 6A prefix
  localparam logic [7:0] SUB_ABS16_TEST = 8'h10;
  localparam logic [7:0] SUB_ABS16_MOD  = 8'h18;
  localparam logic [7:0] SUB_ABS32_TEST = 8'h30;
  localparam logic [7:0] SUB_ABS32_MOD  = 8'h38;

  // unimplemented codes (high nibble of second byte)
  localparam logic [3:0] NIB_MULT_ACC   = 4'h5; // after 01
  localparam logic [3:0] NIB_ACC_CLEAR  = 4'h7; // after 01
  localparam logic [3:0] NIB_PERIPH_MOV = 4'h4; // after 6A

  // bit-operation byte: high nibble 6 or 7, low nibble selects the operation
  localparam logic [3:0] NIB_BITOP_A = 4'h6;
  localparam logic [3:0] NIB_BITOP_B = 4'h7;
  localparam logic [3:0] BITOP_SET   = 4'h0;
  localparam logic [3:0] BITOP_INV   = 4'h1;
  localparam logic [3:0] BITOP_CLR   = 4'h2;
  localparam logic [3:0] BITOP_TST   = 4'h3;

  // immediate byte-operation high nibbles
  localparam logic [3:0] NIB_IMM_ADD = 4'h8;
  localparam logic [3:0] NIB_IMM_ADC = 4'h9;
  localparam logic [3:0] NIB_IMM_CMP = 4'hA;
  localparam logic [3:0] NIB_IMM_SBB = 4'hB;
  localparam logic [3:0] NIB_IMM_OR  = 4'hC;
  localparam logic [3:0] NIB_IMM_XOR = 4'hD;
  localparam logic [3:0] NIB_IMM_AND = 4'hE;
  localparam logic [3:0] NIB_IMM_MOV = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // instruction lengths in bytes
  localparam logic [3:0] LEN_2 = 4'h2;
  localparam logic [3:0] LEN_4 = 4'h4;
  localparam logic [3:0] LEN_6 = 4'h6;
  localparam logic [3:0] LEN_8 = 4'h8;

  // cycle counts per category
  localparam logic [3:0] CYC_0 = 4'h0;
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;

  // states per cycle by target of access
  localparam logic [2:0] COST_ONCHIP      = 3'h1; // every category on on-chip memory
  localparam logic [2:0] COST_P8_BYTE     = 3'h2; // byte over 8-bit peripheral path
  localparam logic [2:0] COST_P8_WORD     = 3'h4; // word over 8-bit peripheral path
  localparam logic [2:0] COST_P16_BYTE    = 3'h2; // byte over 16-bit peripheral path
  localparam logic [2:0] COST_P16_WORD    = 3'h2; // word over 16-bit peripheral path

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {target_onchip_mem, target_periph_8, target_periph_16} access_target_t;

  typedef enum logic [4:0] {
    op_none, add_op, add_with_carry_op, compare_op, subtract_with_borrow_op, or_op, xor_op,
    and_op, move_op, bit_set_op, bit_clear_op, bit_invert_op, bit_test_op, subroutine_call_op,
    multiply_accumulate_op, accumulator_clear_op, peripheral_sync_move_op
  } insn_op_t;

  typedef enum logic [2:0] {
    mode_none, mode_immediate, mode_reg_indirect, mode_abs8, mode_abs16, mode_abs24,
    mode_abs32, mode_mem_indirect
  } addr_mode_t;

  typedef struct packed {
    logic [3:0] fetch;      // instruction fetch
    logic [3:0] branch;     // branch-address read
    logic [3:0] stack;      // stack operation
    logic [3:0] byte_data;  // byte data access
    logic [3:0] word_data;  // word data access
    logic [3:0] internal;   // internal operation
  } cycle_counts_t;

  typedef struct packed {
    insn_op_t   op;              // decoded operation
    addr_mode_t mode;            // operand addressing
    logic [3:0] reg_field;       // register specification
    logic [31:0] operand_addr;   // absolute or table address
    logic [7:0] imm;             // immediate byte
    logic [3:0] length;          // instruction length in bytes
    logic       recognized;      // opcode understood by this decoder
    logic       unimplemented;   // opcode exists in the map but is not executed here
  } decode_t;

endpackage

// ===== src/state_cost_calc.sv
// state_cost_calc: weighted sum of per-category cycle counts.
// assumes: program and stack areas sit in on-chip memory; only data
// accesses may go to a peripheral module.
`timescale 1ns/10ps

module state_cost_calc #(
  parameter int STATE_WIDTH = 8              // width of the state total
) (
  input  wire opdec_pkg::cycle_counts_t  counts,
  input  wire opdec_pkg::access_target_t target,
  output logic [STATE_WIDTH-1:0]         total
);

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] cost_byte;   // states per byte data cycle
  logic [2:0] cost_word;   // states per word data cycle

  // per-target data costs; fetch, branch, stack and internal stay at one state
  always_comb begin
    case (target)
      opdec_pkg::target_periph_8: begin   // one wait per two states
        cost_byte = opdec_pkg::COST_P8_BYTE;  // RQ3
        cost_word = opdec_pkg::COST_P8_WORD;  // RQ3
      end
      opdec_pkg::target_periph_16: begin
        cost_byte = opdec_pkg::COST_P16_BYTE;
        cost_word = opdec_pkg::COST_P16_WORD;
      end
      default: begin                      // on-chip memory
        cost_byte = opdec_pkg::COST_ONCHIP;  // RQ2
        cost_word = opdec_pkg::COST_ONCHIP;  // RQ2
      end
    endcase
  end

  // weighted sum of the six categories
  always_comb begin
    total = STATE_WIDTH'(counts.fetch * opdec_pkg::COST_ONCHIP)       // RQ1
          + STATE_WIDTH'(counts.branch * opdec_pkg::COST_ONCHIP)
          + STATE_WIDTH'(counts.stack * opdec_pkg::COST_ONCHIP)
          + STATE_WIDTH'(counts.byte_data) * STATE_WIDTH'(cost_byte)
          + STATE_WIDTH'(counts.word_data) * STATE_WIDTH'(cost_word)
          + STATE_WIDTH'(counts.internal * opdec_pkg::COST_ONCHIP);   // RQ2
  end

endmodule

// ===== src/cpu_opcode_decode_state_count.sv
// cpu_opcode_decode_state_count: decodes one instruction from the fetch
// stream and totals the states it takes.
// assumes: the whole instruction is presented in one cycle with valid;
// the data target is known from the operand address by the caller.
//
// Operation
// RQ1: execution states are weighted sum of six counts
// RQ2: on-chip memory costs one state per cycle
// RQ3: 8-bit peripheral: byte two, word four states
// RQ4: multiply-accumulate, accumulator-clear, peripheral move unimplemented
// RQ5: 7C/7D: register from field, op from bytes
// RQ6: 7E/7F: 8-bit absolute address from second byte
// RQ7: 6A10/18 16-bit, 6A30/38 32-bit absolute address
// RQ8: bit-set at abs8: two fetch, two byte
// RQ9: memory-indirect call: two fetch, branch, stack
// RQ10: high nibbles 8 to F are immediate byte ops
`timescale 1ns/10ps

module cpu_opcode_decode_state_count #(
  parameter int STATE_WIDTH = 8               // width of the state total
) (
  input  wire logic                                clock,
  input  wire logic                                nrst,
  input  wire logic                                insn_valid,   // instruction bytes present
  input  wire logic [opdec_pkg::FETCH_BYTES-1:0][7:0] insn_bytes, // index 0 is the first byte
  input  wire opdec_pkg::access_target_t           data_target,  // where data accesses go
  output logic                                     result_valid, // one-cycle result strobe
  output opdec_pkg::decode_t                       decoded,      // decode fields
  output opdec_pkg::cycle_counts_t                 cycles,       // per-category cycle counts
  output logic [STATE_WIDTH-1:0]                   exec_states   // total execution states
);

  ////////////////////////////////////////////////////////////////////////////
  // all registered state
  typedef struct packed {
    logic                     valid;   // result strobe
    opdec_pkg::decode_t       dec;     // decoded fields
    opdec_pkg::cycle_counts_t cnt;     // cycle counts
    logic [STATE_WIDTH-1:0]   total;   // weighted sum
  } state_t;

  state_t state_q;                      // current state
  state_t state_d;                      // next state
  opdec_pkg::decode_t       dec_c;      // combinational decode
  opdec_pkg::cycle_counts_t cnt_c;      // combinational counts
  logic [STATE_WIDTH-1:0]   total_c;    // combinational total

  ////////////////////////////////////////////////////////////////////////////
  // operation selected by the low nibble of a bit-operation byte
  function automatic opdec_pkg::insn_op_t bit_op_of(input logic [3:0] nib);
    case (nib)
      opdec_pkg::BITOP_SET: bit_op_of = opdec_pkg::bit_set_op;
      opdec_pkg::BITOP_INV: bit_op_of = opdec_pkg::bit_invert_op;
      opdec_pkg::BITOP_CLR: bit_op_of = opdec_pkg::bit_clear_op;
      opdec_pkg::BITOP_TST: bit_op_of = opdec_pkg::bit_test_op;
      default:              bit_op_of = opdec_pkg::op_none;
    endcase
  endfunction

  // a bit-operation byte is valid when its high nibble is 6 or 7 and the
  // operation fits the family: test-only or modify-only
  function automatic opdec_pkg::insn_op_t bit_op_check(input logic [7:0] opb, input logic test_only);
    opdec_pkg::insn_op_t op;
    op = bit_op_of(opb[3:0]);
    if (opb[7:4] != opdec_pkg::NIB_BITOP_A && opb[7:4] != opdec_pkg::NIB_BITOP_B) begin
      bit_op_check = opdec_pkg::op_none;
    end else if (test_only) begin
      bit_op_check = (op == opdec_pkg::bit_test_op) ? op : opdec_pkg::op_none;
    end else begin
      bit_op_check = (op == opdec_pkg::bit_test_op) ? opdec_pkg::op_none : op;
    end
  endfunction

  // immediate byte operation from the first-byte high nibble
  function automatic opdec_pkg::insn_op_t imm_op_of(input logic [3:0] nib);
    case (nib)
      opdec_pkg::NIB_IMM_ADD: imm_op_of = opdec_pkg::add_op;
      opdec_pkg::NIB_IMM_ADC: imm_op_of = opdec_pkg::add_with_carry_op;
      opdec_pkg::NIB_IMM_CMP: imm_op_of = opdec_pkg::compare_op;
      opdec_pkg::NIB_IMM_SBB: imm_op_of = opdec_pkg::subtract_with_borrow_op;
      opdec_pkg::NIB_IMM_OR:  imm_op_of = opdec_pkg::or_op;
      opdec_pkg::NIB_IMM_XOR: imm_op_of = opdec_pkg::xor_op;
      opdec_pkg::NIB_IMM_AND: imm_op_of = opdec_pkg::and_op;
      opdec_pkg::NIB_IMM_MOV: imm_op_of = opdec_pkg::move_op;
      default:                imm_op_of = opdec_pkg::op_none;
    endcase
  endfunction

  // cycle counts of a memory bit operation: a test reads once, the others
  // read and write back
  function automatic opdec_pkg::cycle_counts_t bit_counts(input opdec_pkg::insn_op_t op,
                                                          input logic [3:0] fetches);
    opdec_pkg::cycle_counts_t c;
    c = '0;
    c.fetch = fetches;
    c.byte_data = (op == opdec_pkg::bit_test_op) ? opdec_pkg::CYC_1 : opdec_pkg::CYC_2; // RQ8
    bit_counts = c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode and cycle counts of the presented instruction
  always_comb begin
    dec_c = '0;
    cnt_c = '0;
    dec_c.op = opdec_pkg::op_none;
    dec_c.mode = opdec_pkg::mode_none;
    case (insn_bytes[0])
      // register-indirect bit operations
      opdec_pkg::OPC_BIT_REG_TEST, opdec_pkg::OPC_BIT_REG_MOD: begin
        dec_c.op = bit_op_check(insn_bytes[2], insn_bytes[0] == opdec_pkg::OPC_BIT_REG_TEST); // RQ5
        dec_c.mode = opdec_pkg::mode_reg_indirect;
        dec_c.reg_field = {1'b0, insn_bytes[1][6:4]};   // RQ5
        dec_c.length = opdec_pkg::LEN_4;
        cnt_c = bit_counts(dec_c.op, opdec_pkg::CYC_2);
      end
      // 8-bit absolute bit operations
      opdec_pkg::OPC_BIT_ABS8_TEST, opdec_pkg::OPC_BIT_ABS8_MOD: begin
        dec_c.op = bit_op_check(insn_bytes[2], insn_bytes[0] == opdec_pkg::OPC_BIT_ABS8_TEST);
        dec_c.mode = opdec_pkg::mode_abs8;
        dec_c.operand_addr = {24'h000000, insn_bytes[1]};  // RQ6
        dec_c.length = opdec_pkg::LEN_4;
        cnt_c = bit_counts(dec_c.op, opdec_pkg::CYC_2);  // RQ8
      end
      // long absolute bit operations and the peripheral-synchronised move
      opdec_pkg::OPC_EXT_6A: begin
        case (insn_bytes[1])
          opdec_pkg::SUB_ABS16_TEST, opdec_pkg::SUB_ABS16_MOD: begin
            dec_c.op = bit_op_check(insn_bytes[4], insn_bytes[1] == opdec_pkg::SUB_ABS16_TEST);
            dec_c.mode = opdec_pkg::mode_abs16;
            dec_c.operand_addr = {16'h0000, insn_bytes[2], insn_bytes[3]};  // RQ7
            dec_c.length = opdec_pkg::LEN_6;
            cnt_c = bit_counts(dec_c.op, opdec_pkg::CYC_3);
          end
          opdec_pkg::SUB_ABS32_TEST, opdec_pkg::SUB_ABS32_MOD: begin
            dec_c.op = bit_op_check(insn_bytes[6], insn_bytes[1] == opdec_pkg::SUB_ABS32_TEST);
            dec_c.mode = opdec_pkg::mode_abs32;
            dec_c.operand_addr = {insn_bytes[2], insn_bytes[3], insn_bytes[4], insn_bytes[5]}; // RQ7
            dec_c.length = opdec_pkg::LEN_8;
            cnt_c = bit_counts(dec_c.op, opdec_pkg::CYC_4);
          end
          default: begin
            if (insn_bytes[1][7:4] == opdec_pkg::NIB_PERIPH_MOV) begin
              dec_c.op = opdec_pkg::peripheral_sync_move_op;  // RQ4
              dec_c.unimplemented = 1'b1;                      // RQ4
            end
          end
        endcase
      end
      // extended prefix: only the unimplemented accumulator forms are decoded
      opdec_pkg::OPC_EXT_01: begin
        if (insn_bytes[1][7:4] == opdec_pkg::NIB_MULT_ACC) begin
          dec_c.op = opdec_pkg::multiply_accumulate_op;  // RQ4
          dec_c.unimplemented = 1'b1;
        end else if (insn_bytes[1][7:4] == opdec_pkg::NIB_ACC_CLEAR) begin
          dec_c.op = opdec_pkg::accumulator_clear_op;    // RQ4
          dec_c.unimplemented = 1'b1;
        end
      end
      // subroutine calls
      opdec_pkg::OPC_CALL_MEMIND: begin
        dec_c.op = opdec_pkg::subroutine_call_op;
        dec_c.mode = opdec_pkg::mode_mem_indirect;
        dec_c.operand_addr = {24'h000000, insn_bytes[1]};
        dec_c.length = opdec_pkg::LEN_2;
        cnt_c.fetch = opdec_pkg::CYC_2;   // RQ9
        cnt_c.branch = opdec_pkg::CYC_2;  // RQ9
        cnt_c.stack = opdec_pkg::CYC_2;   // RQ9
      end
      opdec_pkg::OPC_CALL_ABS24: begin
        dec_c.op = opdec_pkg::subroutine_call_op;
        dec_c.mode = opdec_pkg::mode_abs24;
        dec_c.operand_addr = {8'h00, insn_bytes[1], insn_bytes[2], insn_bytes[3]};
        dec_c.length = opdec_pkg::LEN_4;
        cnt_c.fetch = opdec_pkg::CYC_2;
        cnt_c.stack = opdec_pkg::CYC_2;
        cnt_c.internal = opdec_pkg::CYC_1;
      end
      opdec_pkg::OPC_CALL_REG: begin
        dec_c.op = opdec_pkg::subroutine_call_op;
        dec_c.mode = opdec_pkg::mode_reg_indirect;
        dec_c.reg_field = {1'b0, insn_bytes[1][6:4]};
        dec_c.length = opdec_pkg::LEN_2;
        cnt_c.fetch = opdec_pkg::CYC_2;
        cnt_c.stack = opdec_pkg::CYC_2;
      end
      // immediate byte operations by first-byte high nibble
      default: begin
        if (insn_bytes[0][7]) begin
          dec_c.op = imm_op_of(insn_bytes[0][7:4]);  // RQ10
          dec_c.mode = opdec_pkg::mode_immediate;
          dec_c.reg_field = insn_bytes[0][3:0];
          dec_c.imm = insn_bytes[1];
          dec_c.length = opdec_pkg::LEN_2;
          cnt_c.fetch = opdec_pkg::CYC_1;
        end
      end
    endcase
    dec_c.recognized = (dec_c.op != opdec_pkg::op_none);
    // an opcode that does not execute takes no cycles at all
    if (!dec_c.recognized || dec_c.unimplemented) begin
      cnt_c = '0;                                   // RQ4
      dec_c.length = '0;
      dec_c.mode = opdec_pkg::mode_none;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // weighted state total for the decoded counts
  state_cost_calc #(
    .STATE_WIDTH (STATE_WIDTH)
  ) u_cost (
    .counts (cnt_c),
    .target (data_target),
    .total  (total_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: results are captured only for a presented instruction
  always_comb begin
    state_d = state_q;
    state_d.valid = insn_valid;
    if (insn_valid) begin
      state_d.dec = dec_c;
      state_d.cnt = cnt_c;
      state_d.total = total_c;  // RQ1
    end
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign result_valid = state_q.valid;
  assign decoded      = state_q.dec;
  assign cycles       = state_q.cnt;
  assign exec_states  = state_q.total;

endmodule

// ===== bench/opdec_sva.sv
// opdec_sva: port-level timing and decode checks for the decoder
// assumes: bound onto the decoder top; one clock, async active-low reset
`timescale 1ns/10ps

module opdec_sva #(
  parameter int STATE_WIDTH = 8 // width of the state total
) (
  input logic                                   clock,
  input logic                                   nrst,
  input logic                                   insn_valid,
  input logic [opdec_pkg::FETCH_BYTES-1:0][7:0] insn_bytes,
  input opdec_pkg::access_target_t              data_target,
  input logic                                   result_valid,
  input opdec_pkg::decode_t                     decoded,
  input opdec_pkg::cycle_counts_t               cycles,
  input logic [STATE_WIDTH-1:0]                 exec_states
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // helpers: inputs seen at the last edge and the target-free part of the sum
  logic [opdec_pkg::FETCH_BYTES-1:0][7:0] pb_q; // bytes seen at the last edge
  opdec_pkg::access_target_t              pt_q; // target seen at the last edge
  logic [STATE_WIDTH-1:0]                 base; // fetch, branch, stack, internal at one state
  // capture inputs so results can be tied to their cause
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pb_q <= '0;
      pt_q <= opdec_pkg::target_onchip_mem;
    end else begin
      pb_q <= insn_bytes;
      pt_q <= data_target;
    end
  end
  assign base = STATE_WIDTH'(cycles.fetch) + STATE_WIDTH'(cycles.branch) + STATE_WIDTH'(cycles.stack)
              + STATE_WIDTH'(cycles.internal);
  ////////////////////////////////////////////////////////////////////////////
  // call through the table: request, then its counts
  sequence s_take_call;
    insn_valid && insn_bytes[0] == opdec_pkg::OPC_CALL_MEMIND;
  endsequence
  sequence s_call_done;
    result_valid && cycles == 24'h222000 && decoded.operand_addr == 32'(pb_q[1]);
  endsequence
  a_answer_next: assert property (insn_valid |=> result_valid) else $error("no result after request");
  a_hold_idle: assert property (!insn_valid |=> !result_valid && $stable(exec_states))
    else $error("output moved without request");
  a_weighted_sum: assert property (result_valid && pt_q == opdec_pkg::target_periph_16 |->
    exec_states == base + 2 * cycles.byte_data + 2 * cycles.word_data) else $error("weighted sum wrong");
  a_onchip_unit: assert property (result_valid && pt_q == opdec_pkg::target_onchip_mem |->
    exec_states == base + cycles.byte_data + cycles.word_data) else $error("on-chip cost wrong");
  a_periph8_cost: assert property (result_valid && pt_q == opdec_pkg::target_periph_8 |->
    exec_states == base + 2 * cycles.byte_data + 4 * cycles.word_data) else $error("8-bit path cost wrong");
  a_unimpl_move: assert property (insn_valid && insn_bytes[0] == opdec_pkg::OPC_EXT_6A
    && insn_bytes[1][7:4] == opdec_pkg::NIB_PERIPH_MOV |=> decoded.unimplemented && exec_states == '0)
    else $error("peripheral move executed");
  a_reg_indirect: assert property (insn_valid && insn_bytes[0] == opdec_pkg::OPC_BIT_REG_MOD
    && insn_bytes[2] == 8'h62 |=> decoded.op == opdec_pkg::bit_clear_op
    && decoded.reg_field == {1'b0, pb_q[1][6:4]}) else $error("register field wrong");
  a_abs8_bitset: assert property (insn_valid && insn_bytes[0] == opdec_pkg::OPC_BIT_ABS8_MOD
    && insn_bytes[2] == 8'h70 |=> decoded.operand_addr == 32'(pb_q[1])
    && cycles == 24'h200200) else $error("abs8 set wrong");
  a_abs32_addr: assert property (insn_valid && insn_bytes[1:0] == 16'h386A
    |=> decoded.mode == opdec_pkg::mode_abs32 && decoded.operand_addr == {pb_q[2], pb_q[3], pb_q[4], pb_q[5]})
    else $error("abs32 address wrong");
  a_call_table: assert property (s_take_call |=> s_call_done) else $error("table call counts wrong");
  a_imm_decode: assert property (insn_valid && insn_bytes[0][7] |=> decoded.imm == pb_q[1]
    && decoded.mode == opdec_pkg::mode_immediate && cycles.fetch == 4'h1) else $error("immediate decode wrong");
endmodule

bind cpu_opcode_decode_state_count opdec_sva #(.STATE_WIDTH(STATE_WIDTH)) opdec_sva_inst (.clock, .nrst, .insn_valid,
  .insn_bytes, .data_target, .result_valid, .decoded, .cycles, .exec_states);

// ===== bench/periph_bus_model.sv
// periph_bus_model: tells which party answers a data address
// assumes: peripheral windows sit at the top of the address map
`timescale 1ns/10ps

module periph_bus_model #(
  parameter logic [31:0] P16_BASE = 32'h0000_FE00, // start of the 16-bit module window
  parameter logic [31:0] P8_BASE  = 32'h0000_FF00  // start of the 8-bit module window
) (
  input  wire logic [31:0]          addr,  // operand address of the data access
  output opdec_pkg::access_target_t target // who answers it
);
  // address decode of the module bus
  always_comb begin
    if (addr >= P8_BASE) begin
      target = opdec_pkg::target_periph_8;
    end else if (addr >= P16_BASE) begin
      target = opdec_pkg::target_periph_16;
    end else begin
      target = opdec_pkg::target_onchip_mem;
    end
  end
endmodule

// ===== bench/tb.sv
// tb: directed tests of the opcode decoder and state counter
// assumes: inputs change at the falling edge; results read one edge later
`timescale 1ns/10ps

module tb;
  logic                      clock, nrst, insn_valid, result_valid;
  logic [63:0]               insn_bytes;
  logic [31:0]               data_addr;   // address shown to the bus model
  opdec_pkg::access_target_t data_target;
  opdec_pkg::decode_t        decoded;
  opdec_pkg::cycle_counts_t  cycles;
  logic [7:0]                exec_states;
  int                        mismatches = 0, n_compared = 0;

  cpu_opcode_decode_state_count #(.STATE_WIDTH(8)) cpu_opcode_decode_state_count_inst (.clock, .nrst, .insn_valid,
    .insn_bytes, .data_target, .result_valid, .decoded, .cycles, .exec_states);
  periph_bus_model periph_bus_model_inst (.addr(data_addr), .target(data_target));
  ////////////////////////////////////////////////////////////////////////////
  // clock, then shared helpers
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [63:0] ins(input logic [7:0] b0, b1, b2 = '0, b3 = '0, b4 = '0, b5 = '0, b6 = '0, b7 = '0);
    return {b7, b6, b5, b4, b3, b2, b1, b0};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // present one instruction; caller sits at a falling edge
  task automatic send(input logic [63:0] b, input logic [31:0] a);
    insn_valid = 1'b1;
    insn_bytes = b;
    data_addr = a;
    @(negedge clock);
  endtask
  // counts and total with byte and word state costs sl, sm
  task automatic chk_counts(input logic [3:0] f, j, k, l, m, n, input int sl, sm);
    chk("valid", 1, result_valid);
    chk("counts", {f, j, k, l, m, n}, cycles);
    chk("states", f + j + k + n + l * sl + m * sm, exec_states);
  endtask
  task automatic chk_bit(input int op, md, input logic [31:0] ad, input logic [3:0] f, l, input int sl);
    chk("op", op, 32'(decoded.op));
    chk("mode", md, 32'(decoded.mode));
    chk("addr", ad, decoded.operand_addr);
    chk_counts(f, 0, 0, l, 0, 0, sl, sl);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_abs8;
    send(ins(8'h7F, 8'hC7, 8'h70), 32'h0000_FFC7);
    chk_bit(opdec_pkg::bit_set_op, opdec_pkg::mode_abs8, 32'hC7, 2, 2, 2);
    chk("length", 4, decoded.length);
    // nibbles 0, 2, 1: set, clear, invert
    for (int i = 0; i < 3; i++) begin
      send(ins(8'h7F, 8'h20, {4'h7, 4'(i == 0 ? 0 : 3 - i)}), 32'h0000_1000);
      chk_bit(opdec_pkg::bit_set_op + i, opdec_pkg::mode_abs8, 32'h20, 2, 2, 1);
    end
    send(ins(8'h7E, 8'h10, 8'h73), 32'h0000_FE10);
    chk_bit(opdec_pkg::bit_test_op, opdec_pkg::mode_abs8, 32'h10, 2, 1, 2);
    $display("test abs8 done");
  endtask
  task automatic t_reg;
    send(ins(8'h7D, 8'h50, 8'h62), 32'h0000_1000);
    chk_bit(opdec_pkg::bit_clear_op, opdec_pkg::mode_reg_indirect, 0, 2, 2, 1);
    chk("reg", 5, decoded.reg_field);
    send(ins(8'h7C, 8'h30, 8'h73), 32'h0000_FF00);
    chk_bit(opdec_pkg::bit_test_op, opdec_pkg::mode_reg_indirect, 0, 2, 1, 2);
    chk("reg", 3, decoded.reg_field);
    $display("test reg done");
  endtask
  task automatic t_long;
    send(ins(8'h6A, 8'h10, 8'h12, 8'h34, 8'h73), 32'h0000_FF12);
    chk_bit(opdec_pkg::bit_test_op, opdec_pkg::mode_abs16, 32'h1234, 3, 1, 2);
    send(ins(8'h6A, 8'h18, 8'hFE, 8'h00, 8'h61), 32'h0000_FE00);
    chk_bit(opdec_pkg::bit_invert_op, opdec_pkg::mode_abs16, 32'hFE00, 3, 2, 2);
    send(ins(8'h6A, 8'h38, 8'h89, 8'hAB, 8'hCD, 8'hEF, 8'h70), 32'h0000_FFEF);
    chk_bit(opdec_pkg::bit_set_op, opdec_pkg::mode_abs32, 32'h89AB_CDEF, 4, 2, 2);
    send(ins(8'h6A, 8'h30, 8'h00, 8'h00, 8'h01, 8'h00, 8'h73), 32'h0000_0100);
    chk_bit(opdec_pkg::bit_test_op, opdec_pkg::mode_abs32, 32'h100, 4, 1, 1);
    $display("test long done");
  endtask
  task automatic t_call_unimpl;
    logic [15:0] codes [3] = '{16'h5001, 16'h7001, 16'h406A};
    send(ins(8'h5F, 8'h30), 32'h0000_FF30);
    chk("mode", 32'(opdec_pkg::mode_mem_indirect), 32'(decoded.mode));
    chk_counts(2, 2, 2, 0, 0, 0, 2, 4);
    for (int i = 0; i < 3; i++) begin
      send(ins(codes[i][7:0], codes[i][15:8]), 32'h0000_1000);
      chk("op", opdec_pkg::multiply_accumulate_op + i, 32'(decoded.op));
      chk("unimpl", 2'b11, {decoded.recognized, decoded.unimplemented});
      chk_counts(0, 0, 0, 0, 0, 0, 1, 1);
    end
    $display("test call and unimplemented done");
  endtask
  task automatic t_imm_idle;
    for (int i = 0; i < 8; i++) begin
      send(ins({4'(8 + i), 4'hA}, 8'h5C), 32'h0000_FFFF);
      chk("op", opdec_pkg::add_op + i, 32'(decoded.op));
      chk("imm", 12'hA5C, {decoded.reg_field, decoded.imm});
      chk_counts(1, 0, 0, 0, 0, 0, 2, 4);
    end
    send(ins(8'h7F, 8'hC7, 8'h50), 32'h0000_1000);
    chk("known", 0, decoded.recognized);
    chk("states", 0, exec_states);
    insn_valid = 1'b0;
    @(negedge clock);
    chk("idle", 0, result_valid);
    nrst = 1'b0;
    @(negedge clock);
    chk("cleared", 0, {result_valid, exec_states, decoded.op});
    nrst = 1'b1;
    $display("test immediate and idle done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    insn_valid = 1'b0;
    insn_bytes = '0;
    data_addr = '0;
    repeat (4) @(negedge clock);
    chk("reset", 0, {result_valid, exec_states});
    nrst = 1'b1;
    t_abs8();
    t_reg();
    t_long();
    t_call_unimpl();
    t_imm_idle();
    complete_run();
  end
endmodule
